// ===== common/sadc_pkg.sv
/*
 * constants for the converter mode and result register block:
 * bus addresses, mode field layout, reset values, divider and timing counts.
 * assumes a cpu byte/word memory bus running on the peripheral clock.
 */
`default_nettype none
package sadc_pkg;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] SADC_RESULT_WORD_ADDR = 16'hFF08;
	localparam logic [15:0] SADC_RESULT_BYTE_ADDR = 16'hFF09;
	localparam logic [15:0] SADC_MODE_ADDR = 16'hFF28;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int SADC_CONV_EN_BIT = 7;
	localparam int SADC_FREQ_LSB = 3;
	localparam int SADC_LEVEL_LSB = 1;
	localparam int SADC_COMP_EN_BIT = 0;
	localparam logic [7:0] SADC_MODE_WMASK = 8'hBF;
	localparam logic [7:0] SADC_MODE_RESET = 8'h00;
	localparam logic [15:0] SADC_RESULT_WORD_RESET = 16'h0000;
	localparam logic [7:0] SADC_RESULT_BYTE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	localparam int SADC_RES_BITS = 10;
	localparam logic [5:0] SADC_CONV_CLKS_NORMAL = 6'h16;
	localparam logic [5:0] SADC_CONV_CLKS_LOWREF = 6'h28;
	localparam logic [1:0] SADC_LEVEL_NORMAL = 2'h0;
	localparam logic [1:0] SADC_LEVEL_LOWREF = 2'h1;
	localparam logic [3:0] SADC_DIV_CODE0 = 4'hC;
	localparam logic [3:0] SADC_DIV_CODE1 = 4'h8;
	localparam logic [3:0] SADC_DIV_CODE2 = 4'h6;
	localparam logic [3:0] SADC_DIV_CODE3 = 4'h4;
	localparam logic [3:0] SADC_DIV_CODE4 = 4'h3;
	localparam logic [3:0] SADC_DIV_CODE5 = 4'h2;

	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_SAMPLE,
		SADC_DECIDE,
		SADC_TRANSFER
	} sadc_state_t;
endpackage
`default_nettype wire

// ===== hw/sadc_clkdiv.sv
/*
 * conversion clock divider: one-cycle tick every n peripheral clocks.
 * assumes the frequency code is only changed while run is low.
 */
`timescale 1ns/100ps
`default_nettype none
module sadc_clkdiv
	import sadc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [2:0] freq_code,
	output logic tick
);
	logic [3:0] div_value;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		unique case (freq_code)
			3'h0: div_value = SADC_DIV_CODE0;
			3'h1: div_value = SADC_DIV_CODE1;
			3'h2: div_value = SADC_DIV_CODE2;
			3'h3: div_value = SADC_DIV_CODE3;
			3'h4: div_value = SADC_DIV_CODE4;
			3'h5: div_value = SADC_DIV_CODE5;
			// prohibited codes fall back to the slowest divider
			default: div_value = SADC_DIV_CODE0;
		endcase
	end

	always_comb begin
		cnt_next = 4'h0;
		tick_next = 1'b0;
		if (run) begin
			if (cnt_reg >= div_value - 4'h1) begin
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_reg <= 4'h0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule // sadc_clkdiv
`default_nettype wire

// ===== hw/sadc_top.sv
/*
 * mode register, successive approximation sequencer and result registers
 * of a 10-bit converter.
 * assumes the analog sample-hold, comparator and resistor string sit outside,
 * and that the cpu bus runs on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module sadc_top
	import sadc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_bit_wr,
	input wire logic [2:0] bus_bit_sel,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_rd,
	input wire logic bus_rd_word,
	input wire logic comparator_out,
	output logic [15:0] bus_rdata,
	output logic bus_wait,
	output logic comparator_power,
	output logic comparator_half_ref,
	output logic sample_hold_req,
	output logic [9:0] trial_code,
	output logic [1:0] operating_state,
	output logic conversion_done_irq
);
	// ----------------------------------------------------------------
	// comparator decision
	// ----------------------------------------------------------------
	// the comparator is strobed from the divided ref_clk, so its decision is
	// already in this domain; a two-stage synchroniser would stretch the trial
	// loop to three clocks, more than the fastest conversion clock leaves
	logic comp_decision;

	assign comp_decision = comparator_out;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic wait_reg;
	logic wait_next;
	logic [9:0] result_reg;
	logic [9:0] result_next;
	logic mode_hit;
	logic conv_en;
	logic comp_en;
	logic [2:0] freq_code;
	logic [1:0] level_code;

	assign mode_hit = (bus_addr == SADC_MODE_ADDR);
	assign conv_en = mode_reg[SADC_CONV_EN_BIT];
	assign comp_en = mode_reg[SADC_COMP_EN_BIT];
	assign freq_code = mode_reg[SADC_FREQ_LSB +: 3];
	assign level_code = mode_reg[SADC_LEVEL_LSB +: 2];

	always_comb begin
		mode_next = mode_reg;
		rdata_next = 16'h0000;
		wait_next = 1'b0;
		if (bus_wr && mode_hit) begin
			mode_next = bus_wdata & SADC_MODE_WMASK;
		end else if (bus_bit_wr && mode_hit) begin
			mode_next[bus_bit_sel] = bus_wdata[0];
			mode_next = mode_next & SADC_MODE_WMASK;
		end
		if ((bus_wr || bus_bit_wr) && mode_hit) begin
			wait_next = 1'b1;
		end
		if (bus_rd_word && bus_addr == SADC_RESULT_WORD_ADDR) begin
			rdata_next = {result_reg, 6'h00};
			wait_next = 1'b1;
		end else if (bus_rd && bus_addr == SADC_RESULT_BYTE_ADDR) begin
			rdata_next = {8'h00, result_reg[9:2]};
			wait_next = 1'b1;
		end else if (bus_rd && mode_hit) begin
			rdata_next = {8'h00, mode_reg};
		end
		// byte reads of the word address return zero
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode_reg <= SADC_MODE_RESET;
			rdata_reg <= 16'h0000;
			wait_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
		end
	end

	// ----------------------------------------------------------------
	// conversion clock
	// ----------------------------------------------------------------
	logic conv_tick;

	sadc_clkdiv u_clkdiv (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(conv_en),
		.freq_code(freq_code),
		.tick(conv_tick)
	);

	// ----------------------------------------------------------------
	// successive approximation sequencer
	// ----------------------------------------------------------------
	sadc_state_t state_reg;
	sadc_state_t state_next;
	logic [5:0] tick_cnt_reg;
	logic [5:0] tick_cnt_next;
	logic [3:0] bit_idx_reg;
	logic [3:0] bit_idx_next;
	logic [9:0] sar_reg;
	logic [9:0] sar_next;
	logic irq_next;
	logic [5:0] sample_clks;

	// longer conversion at low reference level
	assign sample_clks = ((level_code == SADC_LEVEL_LOWREF) ? SADC_CONV_CLKS_LOWREF :
		SADC_CONV_CLKS_NORMAL) - 6'(SADC_RES_BITS) - 6'h1;

	always_comb begin
		state_next = state_reg;
		tick_cnt_next = tick_cnt_reg;
		bit_idx_next = bit_idx_reg;
		sar_next = sar_reg;
		result_next = result_reg;
		irq_next = 1'b0;
		unique case (state_reg)
			SADC_IDLE: begin
				if (conv_en) begin
					state_next = SADC_SAMPLE;
					tick_cnt_next = 6'h00;
				end
			end
			SADC_SAMPLE: begin
				if (conv_tick) begin
					tick_cnt_next = tick_cnt_reg + 6'h01;
					if (tick_cnt_reg == sample_clks - 6'h1) begin
						state_next = SADC_DECIDE;
						bit_idx_next = 4'(SADC_RES_BITS - 1);
						sar_next = 10'h200;
					end
				end
			end
			SADC_DECIDE: begin
				if (conv_tick) begin
					if (!comp_decision) begin
						sar_next[bit_idx_reg] = 1'b0;
					end
					if (bit_idx_reg == 4'h0) begin
						state_next = SADC_TRANSFER;
					end else begin
						bit_idx_next = bit_idx_reg - 4'h1;
						sar_next[bit_idx_reg - 4'h1] = 1'b1;
					end
				end
			end
			SADC_TRANSFER: begin
				if (conv_tick) begin
					result_next = sar_reg;
					irq_next = 1'b1;
					state_next = SADC_SAMPLE;
					tick_cnt_next = 6'h00;
				end
			end
		endcase
		if (!conv_en) begin
			state_next = SADC_IDLE;
			result_next = result_reg;
			irq_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= SADC_IDLE;
			tick_cnt_reg <= 6'h00;
			bit_idx_reg <= 4'h0;
			sar_reg <= 10'h000;
			result_reg <= SADC_RESULT_WORD_RESET[15:6];
		end else begin
			state_reg <= state_next;
			tick_cnt_reg <= tick_cnt_next;
			bit_idx_reg <= bit_idx_next;
			sar_reg <= sar_next;
			result_reg <= result_next;
		end
	end

	// ----------------------------------------------------------------
	// analog controls
	// ----------------------------------------------------------------
	logic comp_power_reg;
	logic sh_reg;
	logic sh_next;
	logic [9:0] trial_reg;
	logic [1:0] opstate_reg;
	logic irq_reg;

	assign sh_next = (state_next == SADC_SAMPLE);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			comp_power_reg <= 1'b0;
			sh_reg <= 1'b0;
			trial_reg <= 10'h000;
			opstate_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			comp_power_reg <= comp_en;
			sh_reg <= sh_next;
			trial_reg <= sar_next;
			opstate_reg <= {conv_en, comp_en};
			irq_reg <= irq_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign bus_wait = wait_reg;
	assign comparator_power = comp_power_reg;
	assign comparator_half_ref = comp_power_reg;
	assign sample_hold_req = sh_reg;
	assign trial_code = trial_reg;
	assign operating_state = opstate_reg;
	assign conversion_done_irq = irq_reg;
endmodule // sadc_top
`default_nettype wire

// ===== sim/sadc_analog_model.sv
/* behavioural comparator and resistor string.
   assumes trial_code is a registered output of the block. */
`timescale 1ns/100ps
`default_nettype none
module sadc_analog_model (
	input wire logic ref_clk,
	input wire logic comparator_power,
	input wire logic [9:0] trial_code,
	input wire logic [9:0] vin,
	output logic comparator_out
);
	logic junk = 1'b0;
	// unpowered comparator gives noise, never a stale decision
	always @(posedge ref_clk) junk <= ~junk;
	// decision at half-reference bias only when powered
	assign comparator_out = comparator_power ? (vin >= trial_code) : junk;
endmodule // sadc_analog_model
`default_nettype wire

// ===== sim/sadc_top_bench.sv
/* self-checking bench for the converter register block.
   drives the cpu bus directly; the analog side is a model. */
`timescale 1ns/100ps
`default_nettype none
module sadc_top_bench;
	import sadc_pkg::*;
	logic ref_clk = 0, reset = 1, bus_wr = 0, bus_bit_wr = 0, bus_rd = 0, bus_rd_word = 0;
	logic [2:0] bus_bit_sel = 0;
	logic [7:0] bus_wdata = 0;
	logic [15:0] bus_addr = 0, bus_rdata, q, sv;
	logic [9:0] trial_code, vin = 0;
	logic [1:0] operating_state;
	logic bus_wait, w, comparator_out, comparator_power, sample_hold_req, conversion_done_irq;
	logic [3:0] dv [6] = '{SADC_DIV_CODE0, SADC_DIV_CODE1, SADC_DIV_CODE2,
		SADC_DIV_CODE3, SADC_DIV_CODE4, SADC_DIV_CODE5};
	int miscompares = 0, tests_run = 0, n;
	always #2 ref_clk = ~ref_clk;
	sadc_top u_sadc_top (.ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_bit_sel(bus_bit_sel),
		.bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_rd_word(bus_rd_word),
		.comparator_out(comparator_out), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
		.comparator_power(comparator_power), .comparator_half_ref(),
		.sample_hold_req(sample_hold_req), .trial_code(trial_code),
		.operating_state(operating_state), .conversion_done_irq(conversion_done_irq));
	sadc_analog_model u_sadc_analog_model (.ref_clk(ref_clk),
		.comparator_power(comparator_power), .trial_code(trial_code), .vin(vin),
		.comparator_out(comparator_out));
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one-cycle strobe; answer is taken at the following edge
	task automatic acc(input logic [15:0] a, input logic wr, rd, rw, bw, input logic [7:0] d);
		@(posedge ref_clk) #1;
		bus_addr = a;
		bus_wr = wr;
		bus_rd = rd;
		bus_rd_word = rw;
		bus_bit_wr = bw;
		bus_bit_sel = d[6:4];
		bus_wdata = bw ? {7'h00, d[0]} : d;
		@(posedge ref_clk) #1;
		{bus_wr, bus_rd, bus_rd_word, bus_bit_wr} = 4'h0;
		q = bus_rdata;
		w = bus_wait;
	endtask
	task automatic wait_irq;
		n = 0;
		do begin
			@(posedge ref_clk) #1;
			n++;
		end while (!conversion_done_irq && n < 2000);
		if (n >= 2000) begin
			miscompares++;
			stop_test();
		end
	endtask
	task automatic t_regs;
		acc(SADC_MODE_ADDR, 0, 1, 0, 0, 0);
		check(q, 16'h0000);
		acc(SADC_RESULT_WORD_ADDR, 0, 0, 1, 0, 0);
		check(q, 16'h0000);
		acc(SADC_RESULT_BYTE_ADDR, 0, 1, 0, 0, 0);
		check(q, 16'h0000);
		acc(SADC_MODE_ADDR, 1, 0, 0, 0, 8'h7F);
		check({15'h0, w}, 16'h0001);
		// operating state lags the mode register by one clock
		@(posedge ref_clk) #1;
		check({14'h0, operating_state}, 16'h0001);
		acc(SADC_MODE_ADDR, 0, 1, 0, 0, 0);
		check(q, 16'h003F);
		acc(16'h1234, 0, 0, 1, 0, 0);
		check({q[14:0], w}, 16'h0000);
		acc(SADC_MODE_ADDR, 1, 0, 0, 0, 8'h01);
		repeat (250) @(posedge ref_clk);
	endtask
	task automatic t_timing;
		for (int lv = 0; lv < 2; lv++) begin
			for (int f = 0; f < 6; f++) begin
				vin = {lv[0], f[2:0], 6'h2B};
				acc(SADC_MODE_ADDR, 1, 0, 0, 0, {2'b10, f[2:0], 1'b0, lv[0], 1'b1});
				wait_irq();
				wait_irq();
				check(16'(n), 16'(dv[f] * (lv ? SADC_CONV_CLKS_LOWREF : SADC_CONV_CLKS_NORMAL)));
				acc(SADC_RESULT_WORD_ADDR, 0, 0, 1, 0, 0);
				check(q, {vin, 6'h00});
				check({15'h0, w}, 16'h0001);
				acc(SADC_RESULT_BYTE_ADDR, 0, 1, 0, 0, 0);
				check(q, {8'h00, vin[9:2]});
				// stop before the timing fields change
				acc(SADC_MODE_ADDR, 1, 0, 0, 0, 8'h01);
			end
		end
	endtask
	task automatic t_abort;
		vin = 10'h3FF;
		acc(SADC_MODE_ADDR, 1, 0, 0, 0, 8'hA9);
		wait_irq();
		acc(SADC_RESULT_WORD_ADDR, 0, 0, 1, 0, 0);
		sv = q;
		vin = 10'h001;
		repeat (20) @(posedge ref_clk);
		acc(SADC_MODE_ADDR, 0, 0, 0, 1, 8'h70);
		n = 0;
		repeat (300) begin
			@(posedge ref_clk) #1;
			n += conversion_done_irq;
		end
		check(16'(n), 16'h0000);
		acc(SADC_RESULT_WORD_ADDR, 0, 0, 1, 0, 0);
		check(q, sv);
		acc(SADC_MODE_ADDR, 0, 0, 0, 1, 8'h00);
		acc(SADC_MODE_ADDR, 0, 1, 0, 0, 0);
		check(q, 16'h0028);
		check({13'h0, comparator_power, operating_state}, 16'h0000);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		#1 reset = 0;
		t_regs();
		t_timing();
		t_abort();
		stop_test();
	end
endmodule // sadc_top_bench
`default_nettype wire

// ===== sim/sadc_top_props.sv
/* port checker for the converter register block.
   bound onto sadc_top; needs sadc_pkg compiled first. */
`timescale 1ns/100ps
`default_nettype none
module sadc_top_props
	import sadc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic bus_rd_word,
	input wire logic [15:0] bus_rdata,
	input wire logic bus_wait,
	input wire logic comparator_power,
	input wire logic comparator_half_ref,
	input wire logic sample_hold_req,
	input wire logic [9:0] trial_code,
	input wire logic [1:0] operating_state,
	input wire logic conversion_done_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_wait_wr;
		bus_wr && bus_addr == SADC_MODE_ADDR |=> bus_wait;
	endproperty
	a_wait_wr: assert property (p_wait_wr) else $error("no wait after mode write");
	property p_wait_rd;
		bus_rd_word && bus_addr == SADC_RESULT_WORD_ADDR |=> bus_wait;
	endproperty
	a_wait_rd: assert property (p_wait_rd) else $error("no wait after result read");
	property p_low_zero;
		bus_rd_word && bus_addr == SADC_RESULT_WORD_ADDR |=> bus_rdata[5:0] == 6'h00;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low result bits not zero");
	property p_comp;
		operating_state[0] == comparator_power && comparator_half_ref == comparator_power;
	endproperty
	a_comp: assert property (p_comp) else $error("comparator state mismatch");
	property p_stop;
		!operating_state[1] && $past(!operating_state[1]) |-> !conversion_done_irq && !sample_hold_req;
	endproperty
	a_stop: assert property (p_stop) else $error("activity while stopped");
	property p_irq_gap;
		conversion_done_irq |=> !conversion_done_irq [*8];
	endproperty
	a_irq_gap: assert property (p_irq_gap) else $error("completion pulses too close");
	property p_msb;
		$fell(sample_hold_req) && operating_state[1] |-> ##[0:1] trial_code == 10'h200;
	endproperty
	a_msb: assert property (p_msb) else $error("first trial is not msb");
	property p_idle;
		!bus_rd && !bus_rd_word |=> bus_rdata == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	c_irq: cover property (conversion_done_irq);
	c_abort: cover property ($fell(operating_state[1]));
	c_word: cover property (bus_rd_word && bus_addr == SADC_RESULT_WORD_ADDR);
endmodule // sadc_top_props
bind sadc_top sadc_top_props u_sadc_top_props (.*);
`default_nettype wire
